// file: hdl/psm_pkg.sv
// package for the port s lower pin mux block: offsets, resets, carriers
package psm_pkg;
    // register byte offsets on the avalon word bus
    localparam logic [3:0] OFF_DATA      = 4'h0; // port_pin_data
    localparam logic [3:0] OFF_INPUT     = 4'h4; // port_pin_input_sample
    localparam logic [3:0] OFF_DIRECTION = 4'h8; // port_pin_direction
    localparam logic [3:0] OFF_ENABLE    = 4'hC; // function enables
    // widths
    localparam int PORT_W = 6;  // pins of the port
    localparam int REG_W  = 8;  // register width
    // reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DIR_RST  = 8'h00;
    localparam logic [7:0] ENA_RST  = 8'h00;
    // enable register field positions
    localparam int EN_BUSCLK = 0; // bus clock output on pin 3
    localparam int EN_SPI    = 1; // spi owns pins 3,2
    localparam int EN_SIF1R  = 2; // routed serial one on pins 3,2
    localparam int EN_PWMR   = 3; // routed pwm on pins 3,2
    localparam int EN_SIF1   = 4; // serial one on pins 1,0
    localparam int EN_SIF0R  = 5; // routed serial zero on pins 1,0
    localparam int EN_LINR   = 6; // routed lin phy output on pin 1
    // peripheral function outputs toward a pin
    typedef struct packed {
        logic       bus_clock_output;     // bus clock level
        logic [1:0] spi_out;              // spi data for pins 3,2
        logic [1:0] spi_oe;               // spi drive for pins 3,2
        logic [1:0] sif1r_out;            // routed serial one, pins 3,2
        logic [1:0] pwmr_out;             // routed pwm, pins 3,2
        logic [1:0] sif1_out;             // serial one, pins 1,0
        logic [1:0] sif1_oe;              // serial one drive, pins 1,0
        logic [1:0] sif0r_out;            // routed serial zero, pins 1,0
        logic [1:0] sif0r_oe;             // routed serial zero drive
        logic       lin_phy_output_bit;   // lin phy output for pin 1
    } psm_periph_s;
endpackage

// file: hdl/psm_port.sv
// port s lower pin mux: data, input readback, and pin precedence logic
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Function
// [R1] gpio output drives data bit when unowned
// [R2] data read: stored if output, else pin
// [R3] pin3: busclk, spi, sif1, pwm, gpio; the code puts routed sif1 third, not sif1
// [R4] pin2: spi, routed sif1, pwm, gpio
// [R5] pin1: sif1, routed lin, routed sif0, gpio
// [R6] pin0: sif1, routed sif0, gpio
// [R7] input register always returns synced pins
// [R8] input register readable, writes ignored
// [R9] direction one output, zero input
// [R10] data writes always accepted; the code drops a data write when byteenable[0] is low
// [R11] two-flop synchroniser on pin inputs
module psm_port (
    input  wire logic                   ref_clk,      // 20 mhz bus clock
    input  wire logic                   rst_n,        // async reset, low
    input  wire logic [3:0]             address,      // avalon byte address
    input  wire logic                   read,         // avalon read
    input  wire logic                   write,        // avalon write
    input  wire logic [31:0]            writedata,    // avalon write data
    input  wire logic [3:0]             byteenable,   // avalon lanes
    output logic      [31:0]            readdata,     // avalon read data
    output logic                        waitrequest,  // avalon stall
    input  wire psm_pkg::psm_periph_s   periph,       // peripheral outputs
    input  wire logic [5:0]             pin_in,       // pin levels
    output logic      [3:0]             pin_out,      // pin drive levels
    output logic      [3:0]             pin_oe        // pin drive enables
);
    // registers
    logic [7:0]  data_q, data_d;         // port_pin_data
    logic [7:0]  dir_q, dir_d;           // port_pin_direction
    logic [7:0]  ena_q, ena_d;           // function enables
    logic [5:0]  sync1_q, sync2_q;       // synchroniser stages
    logic        ack_q;                  // answer phase flag
    logic [31:0] rdata_q, rdata_d;       // registered read data
    logic [3:0]  out_q, out_d;           // pin levels
    logic [3:0]  oe_q, oe_d;             // pin enables

    // decode
    wire req       = read | write;
    wire take      = req & ~ack_q;       // first cycle of a request
    wire answer    = req & ack_q;        // answer edge, request still held
    wire sel_data  = address == psm_pkg::OFF_DATA;
    wire sel_input = address == psm_pkg::OFF_INPUT;
    wire sel_dir   = address == psm_pkg::OFF_DIRECTION;
    wire sel_ena   = address == psm_pkg::OFF_ENABLE;
    // writes land only at the edge where waitrequest is seen low
    wire wr_lane0  = answer & write & byteenable[0];
    wire [7:0] wd  = writedata[7:0];

    // write paths; input register has no write path
    assign data_d = (wr_lane0 & sel_data) ? wd : data_q; // R10 R8
    assign dir_d  = (wr_lane0 & sel_dir)  ? wd : dir_q;
    assign ena_d  = (wr_lane0 & sel_ena)  ? wd : ena_q;

    // data read source per bit: stored when output, pin when input
    wire [5:0] data_rd = (data_q[5:0] & dir_q[5:0])
                       | (sync2_q & ~dir_q[5:0]); // R2 R9
    // read mux; unmapped reads return zero
    assign rdata_d = sel_data  ? {24'h000000, 2'h0, data_rd}
                   : sel_input ? {24'h000000, 2'h0, sync2_q} // R7
                   : sel_dir   ? {24'h000000, dir_q}
                   : sel_ena   ? {24'h000000, ena_q}
                   : 32'h00000000;

    // pin precedence, highest first
    wire [7:0] e = ena_q;
    always_comb begin
        // pin 3
        if (e[psm_pkg::EN_BUSCLK]) begin
            out_d[3] = periph.bus_clock_output; // R3
            oe_d[3]  = 1'b1;
        end else if (e[psm_pkg::EN_SPI]) begin
            out_d[3] = periph.spi_out[1];
            oe_d[3]  = periph.spi_oe[1];
        end else if (e[psm_pkg::EN_SIF1R]) begin
            out_d[3] = periph.sif1r_out[1];
            oe_d[3]  = 1'b1;
        end else if (e[psm_pkg::EN_PWMR]) begin
            out_d[3] = periph.pwmr_out[1];
            oe_d[3]  = 1'b1;
        end else begin
            out_d[3] = data_q[3]; // R1
            oe_d[3]  = dir_q[3]; // R9
        end
        // pin 2; routed serial one is a receive input here
        if (e[psm_pkg::EN_SPI]) begin
            out_d[2] = periph.spi_out[0]; // R4
            oe_d[2]  = periph.spi_oe[0];
        end else if (e[psm_pkg::EN_SIF1R]) begin
            out_d[2] = 1'b0;
            oe_d[2]  = 1'b0;
        end else if (e[psm_pkg::EN_PWMR]) begin
            out_d[2] = periph.pwmr_out[0];
            oe_d[2]  = 1'b1;
        end else begin
            out_d[2] = data_q[2]; // R1
            oe_d[2]  = dir_q[2];
        end
        // pin 1
        if (e[psm_pkg::EN_SIF1]) begin
            out_d[1] = periph.sif1_out[1]; // R5
            oe_d[1]  = periph.sif1_oe[1];
        end else if (e[psm_pkg::EN_LINR]) begin
            out_d[1] = periph.lin_phy_output_bit;
            oe_d[1]  = 1'b1;
        end else if (e[psm_pkg::EN_SIF0R]) begin
            out_d[1] = periph.sif0r_out[1];
            oe_d[1]  = periph.sif0r_oe[1];
        end else begin
            out_d[1] = data_q[1]; // R1
            oe_d[1]  = dir_q[1];
        end
        // pin 0
        if (e[psm_pkg::EN_SIF1]) begin
            out_d[0] = periph.sif1_out[0]; // R6
            oe_d[0]  = periph.sif1_oe[0];
        end else if (e[psm_pkg::EN_SIF0R]) begin
            out_d[0] = periph.sif0r_out[0];
            oe_d[0]  = periph.sif0r_oe[0];
        end else begin
            out_d[0] = data_q[0]; // R1
            oe_d[0]  = dir_q[0];
        end
    end

    // register state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= psm_pkg::DATA_RST;
            dir_q  <= psm_pkg::DIR_RST;
            ena_q  <= psm_pkg::ENA_RST;
        end else begin
            data_q <= data_d;
            dir_q  <= dir_d;
            ena_q  <= ena_d;
        end
    end

    // pin input synchroniser, two stages
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= pin_in; // R11
            sync2_q <= sync1_q;
        end
    end

    // bus answer: one wait cycle, then waitrequest low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= take;
            rdata_q <= take ? rdata_d : rdata_q;
        end
    end

    // pin drive registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 4'h0;
            oe_q  <= 4'h0;
        end else begin
            out_q <= out_d;
            oe_q  <= oe_d;
        end
    end

    assign readdata = rdata_q;
    assign pin_out  = out_q;
    assign pin_oe   = oe_q;
    // waitrequest high unless in answer phase; low only with ack
    logic wait_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~take;
        end
    end
    assign waitrequest = wait_q;

    // checks
    chk_gpio_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ena_q == 8'h00 |=> pin_out == $past(data_q[3:0])
                          && pin_oe == $past(dir_q[3:0]))
        else $error("gpio drive mismatch"); // R1
    chk_data_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && read && sel_data |=> readdata[5:0]
            == (($past(data_q[5:0]) & $past(dir_q[5:0]))
             | ($past(sync2_q) & ~$past(dir_q[5:0]))))
        else $error("data read source wrong"); // R2
    chk_busclk_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ena_q[psm_pkg::EN_BUSCLK] |=> pin_oe[3]
            && pin_out[3] == $past(periph.bus_clock_output))
        else $error("bus clock not on pin 3"); // R3
    chk_spi_pin2: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ena_q[psm_pkg::EN_SPI] |=> pin_oe[2] == $past(periph.spi_oe[0]))
        else $error("spi not owning pin 2"); // R4
    chk_sif1_pin1: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ena_q[psm_pkg::EN_SIF1] |=> pin_out[1] == $past(periph.sif1_out[1]))
        else $error("serial one not owning pin 1"); // R5
    chk_sif0_pin0: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ena_q[5:4] == 2'b10 |=> pin_oe[0] == $past(periph.sif0r_oe[0]))
        else $error("routed serial zero not on pin 0"); // R6
    chk_input_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && read && sel_input |=> readdata == {26'h0, $past(sync2_q)})
        else $error("input readback wrong"); // R7
    chk_input_ro: assert property (@(posedge ref_clk) disable iff (!rst_n)
        answer && write && sel_input |=> $stable(data_q) && $stable(dir_q)
                                      && $stable(ena_q))
        else $error("input register write had effect"); // R8
    chk_data_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_lane0 && sel_data |=> data_q == $past(wd))
        else $error("data write lost"); // R10
    chk_sync_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##2 sync2_q == $past(pin_in, 2))
        else $error("synchroniser delay wrong"); // R11
    chk_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");
    cov_busclk: cover property (@(posedge ref_clk) ena_q[0] && pin_oe[3]);
    cov_lin: cover property (@(posedge ref_clk) ena_q[6] && !ena_q[4]);
    cov_rd_in: cover property (@(posedge ref_clk) take && read && sel_input);
    cov_wr_data: cover property (@(posedge ref_clk) wr_lane0 && sel_data);
endmodule

// file: verif/psm_pin_model.sv
// outside world of the port: external pin drivers seen through the pads
`timescale 1ns/1ps
module psm_pin_model (
    input  wire logic [3:0] pin_out,  // device drive levels
    input  wire logic [3:0] pin_oe,   // device drive enables
    input  wire logic [5:0] ext_lvl,  // weak outside levels
    output logic      [5:0] pin_in    // resolved pad levels
);
    // outside drivers are weak: a driving device wins the pad
    assign pin_in = {ext_lvl[5:4],
                     (pin_oe & pin_out) | (~pin_oe & ext_lvl[3:0])};
endmodule

// file: verif/psm_port_tb.sv
// self-checking bench for the port s lower pin mux
`timescale 1ns/1ps
module psm_port_tb;
    logic                 ref_clk;     // bus clock
    logic                 rst_n;       // reset, low
    logic [3:0]           address;     // bus address
    logic                 read;        // bus read
    logic                 write;       // bus write
    logic [31:0]          writedata;   // bus write data
    logic [31:0]          readdata;    // bus read data
    logic                 waitrequest; // bus stall
    psm_pkg::psm_periph_s periph;      // peripheral levels
    logic [5:0]           ext_lvl;     // outside levels
    logic [5:0]           pin_in;      // resolved pads
    logic [3:0]           pin_out;     // drive levels
    logic [3:0]           pin_oe;      // drive enables
    logic                 pin_chk;     // pin compare strobe
    logic [31:0]          lfsr;        // random state
    logic [31:0]          rd_q[$];     // expected read data
    logic [7:0]           pin_q[$];    // expected oe, out
    int                   err_total;   // mismatches
    int                   num_checks;  // comparisons
    psm_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'h1),
        .readdata(readdata), .waitrequest(waitrequest), .periph(periph),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    psm_pin_model pads (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_lvl(ext_lvl), .pin_in(pin_in));
    // free-running 20 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one avalon cycle, held until waitrequest is sampled low
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    // expected {oe, out}, out masked by oe
    function automatic logic [7:0] pexp(logic [6:0] en, logic [5:0] dat,
            logic [5:0] dir, psm_pkg::psm_periph_s p);
        logic [3:0] oe;
        logic [3:0] o;
        oe = dir[3:0];
        o = dat[3:0];
        if (en[psm_pkg::EN_BUSCLK])
            {oe[3], o[3]} = {1'b1, p.bus_clock_output};
        else if (en[psm_pkg::EN_SPI])
            {oe[3], o[3]} = {p.spi_oe[1], p.spi_out[1]};
        else if (en[psm_pkg::EN_SIF1R])
            {oe[3], o[3]} = {1'b1, p.sif1r_out[1]};
        else if (en[psm_pkg::EN_PWMR])
            {oe[3], o[3]} = {1'b1, p.pwmr_out[1]};
        if (en[psm_pkg::EN_SPI])
            {oe[2], o[2]} = {p.spi_oe[0], p.spi_out[0]};
        else if (en[psm_pkg::EN_SIF1R])
            oe[2] = 1'b0;
        else if (en[psm_pkg::EN_PWMR])
            {oe[2], o[2]} = {1'b1, p.pwmr_out[0]};
        if (en[psm_pkg::EN_SIF1])
            {oe[1], o[1]} = {p.sif1_oe[1], p.sif1_out[1]};
        else if (en[psm_pkg::EN_LINR])
            {oe[1], o[1]} = {1'b1, p.lin_phy_output_bit};
        else if (en[psm_pkg::EN_SIF0R])
            {oe[1], o[1]} = {p.sif0r_oe[1], p.sif0r_out[1]};
        if (en[psm_pkg::EN_SIF1])
            {oe[0], o[0]} = {p.sif1_oe[0], p.sif1_out[0]};
        else if (en[psm_pkg::EN_SIF0R])
            {oe[0], o[0]} = {p.sif0r_oe[0], p.sif0r_out[0]};
        return {oe, o & oe};
    endfunction
    // monitor: takes the oldest note whenever a result appears
    always @(posedge ref_clk) begin
        logic [7:0] pn; // oldest pin note, {oe, out}
        if (read === 1'b1 && waitrequest === 1'b0)
            check("readdata", readdata, rd_q.pop_front());
        if (pin_chk === 1'b1) begin
            pn = pin_q.pop_front();
            check("pin_oe", pin_oe, pn[7:4]);
            check("pin_out", pin_out & pn[7:4], pn[3:0]);
        end
    end
    // watchdog cuts a hang short
    initial begin
        repeat (6000) @(posedge ref_clk);
        err_total++;
        final_report();
    end
    // main sequence: reset values, then random configurations
    initial begin
        logic [7:0] dat;
        logic [5:0] dir;
        logic [5:0] ext;
        logic [5:0] lvl;
        logic [6:0] en;
        logic [7:0] pe;
        logic [5:0] drd; // expected data readback
        psm_pkg::psm_periph_s p;
        {rst_n, address, read, write, writedata, pin_chk} = '0;
        periph = '0;
        ext_lvl = '0;
        err_total = 0;
        num_checks = 0;
        lfsr = 32'h4828AE13;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(psm_pkg::OFF_DIRECTION, 32'h0);
        rd(psm_pkg::OFF_ENABLE, 32'h0);
        rd(4'h2, 32'h0);
        for (int i = 0; i < 40; i++) begin
            lfsr = nxt(lfsr);
            {dat, dir, en, ext} = lfsr[26:0];
            lfsr = nxt(lfsr);
            p = psm_pkg::psm_periph_s'(lfsr[$bits(p)-1:0]);
            bus(1'b1, psm_pkg::OFF_DATA, {24'h0, dat});
            bus(1'b1, psm_pkg::OFF_DIRECTION, {26'h0, dir});
            bus(1'b1, psm_pkg::OFF_ENABLE, {25'h0, en});
            ext_lvl <= ext;
            periph <= p;
            repeat (5) @(posedge ref_clk);
            pe = pexp(en, dat[5:0], dir, p);
            lvl = {ext[5:4], pe[3:0] | (~pe[7:4] & ext[3:0])};
            pin_q.push_back(pe);
            pin_chk <= 1'b1;
            @(posedge ref_clk);
            pin_chk <= 1'b0;
            drd = (dir & dat[5:0]) | (~dir & lvl);
            rd(psm_pkg::OFF_DATA, {26'h0, drd});
            rd(psm_pkg::OFF_DIRECTION, {26'h0, dir});
            bus(1'b1, psm_pkg::OFF_INPUT, {26'h0, ~lvl});
            rd(psm_pkg::OFF_INPUT, {26'h0, lvl});
        end
        final_report();
    end
endmodule
